/* src/bcp_pkg.sv */
// package: constants and carriers for the breathing clock and stimulus control block
package bcp_pkg;

  // ----------------------------------------------------------------
  // register offsets (plain port, byte-wide registers)
  // ----------------------------------------------------------------
  localparam logic [3:0] BCP_ADDR_CFG3   = 4'h3;
  localparam logic [3:0] BCP_ADDR_ELECTRODE_OFF_CTRL_REG   = 4'h4;
  localparam logic [3:0] BCP_ADDR_STIM   = 4'h5;
  localparam logic [3:0] BCP_ADDR_BREATH = 4'h6;
  localparam logic [3:0] BCP_ADDR_CFG4   = 4'h7;
  localparam logic [3:0] BCP_ADDR_GPIO   = 4'h8;
  localparam logic [3:0] BCP_ADDR_STAT   = 4'h9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BCP_CFG3_REF_INT_BIT  = 3;
  localparam int BCP_CFG3_BD_PD_BIT    = 2;
  localparam int BCP_CFG4_FREQ_LSB     = 5;
  localparam int BCP_CFG4_CT_BD_BIT    = 2;
  localparam int BCP_BREATH_PH_LSB     = 2;
  localparam int BCP_BREATH_MODE_LSB   = 0;
  localparam int BCP_STIM_SEL_LSB      = 1;
  localparam int BCP_STIM_PD_BIT       = 0;
  localparam int BCP_ELECTRODE_OFF_CTRL_REG_TH_LSB       = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BCP_CFG3_RST   = 8'h04;
  localparam logic [7:0] BCP_CFG4_RST   = 8'h00;
  localparam logic [7:0] BCP_BREATH_RST = 8'h00;
  localparam logic [7:0] BCP_STIM_RST   = 8'h01;
  localparam logic [7:0] BCP_ELECTRODE_OFF_CTRL_REG_RST   = 8'h00;
  localparam logic [7:0] BCP_GPIO_RST   = 8'h0F;

  localparam logic [1:0] BCP_MODE_NONE  = 2'h0;
  localparam logic [1:0] BCP_MODE_EXT   = 2'h1;

  // filter settling in output-data periods
  localparam int BCP_SETTLE_PERIODS = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bcp_bus_req_type;

  typedef struct packed {
    logic       stim_amp_on;
    logic [2:0] stim_odd_ch;
    logic [2:0] stim_even_ch;
    logic       body_drive_amp_on;
    logic       body_drive_ref_internal;
    logic       central_terminal_to_body_drive;
    logic [2:0] electrode_off_ctrl_reg_threshold;
    logic       bd_electrode_off_ctrl_reg_current_en;
  } bcp_analog_ctrl_type;

endpackage : bcp_pkg

/* src/bcp_clkgen.sv */
// excitation clock generator: divided in-phase and out-of-phase clocks
`timescale 1ns/1ns
module bcp_clkgen #(
  parameter int DIV_W = 8
) (
  input  wire logic       clk_sys_i,    // system clock
  input  wire logic       rst_n_i,      // async reset, active low
  input  wire logic       run_i,        // generator enabled
  input  wire logic [2:0] freq_sel_i,   // frequency code
  input  wire logic [2:0] phase_sel_i,  // phase code
  output logic            clk_in_o,     // in-phase clock
  output logic            clk_out_o     // out-of-phase clock
);
  import bcp_pkg::*;

  // slowest code needs a half period of 256 cycles, one bit above the counter
  if (DIV_W < 8) begin : g_bad_div
    $error("bcp_clkgen: DIV_W too small");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             ph_in;
    logic             ph_out;
  } bcp_gen_state_type;

  bcp_gen_state_type st_reg;
  bcp_gen_state_type st_next;
  logic [DIV_W:0]    half;
  logic [DIV_W-1:0]  last;
  logic [DIV_W-1:0]  shift;

  // half period = 2^(freq_sel+1) cycles; phase offset = (phase_sel mod 4) eighths of a period
  assign half  = (DIV_W+1)'(2) << freq_sel_i;
  assign last  = DIV_W'(half - (DIV_W+1)'(1));
  assign shift = DIV_W'(((32'(half) * 32'(phase_sel_i)) >> 2) % 32'(half));

  always_comb begin
    st_next = st_reg;
    if (!run_i) begin
      st_next = '0;
    end else begin
      if (st_reg.cnt >= last) begin
        st_next.cnt   = '0;
        st_next.ph_in = ~st_reg.ph_in;
      end else begin
        st_next.cnt = st_reg.cnt + DIV_W'(1);
      end
      // second clock turns at the shifted count, so phase 0 is an exact inverse
      if (st_next.cnt == shift) begin
        st_next.ph_out = ~st_next.ph_in;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_in_o  = st_reg.ph_in;
  assign clk_out_o = st_reg.ph_out;

endmodule // bcp_clkgen

/* src/bcp_top.sv */
// breathing clock, stimulus path and body-drive control registers
// ----------------------------------------------------------------
// Summary of operation
// - mode 00 gives no excitation, 01 drives clocks on pins two to four
// - external mode forces pins two, three and four to outputs
// - pin two carries XOR of pins three and four
// - pin three in-phase clock, pin four out-of-phase clock
// - frequency select is 3-bit field in config_reg_four
// - phase select is 3-bit field in breathing_config_reg
// - stimulus path routes one odd and one even channel
// - channel selection comes from stim_pulse_ctrl_reg bits 4 to 1
// - stim_amp_powerdown keeps stimulus amplifiers off
// - stimulus outputs muxed with test signals on shared pins
// - detector input on gp_pin_one reported in general-purpose pin data
// - filter output takes three data periods to settle after step
// - body_drive_amp_powerdown keeps body-drive amplifier off
// - body_drive_ref_internal picks internal or external reference
// - central_terminal_to_body_drive routes buffered copy to body-drive path
// - electrode-off thresholds from electrode_off_ctrl_reg bits 7 to 5
// - powered body-drive amp disables its electrode-off current source
// ----------------------------------------------------------------
`timescale 1ns/1ns
module bcp_top #(
  parameter int DIV_W = 8
) (
  input  wire logic                      clk_sys_i,        // system clock, 25 MHz
  input  wire logic                      rst_n_i,          // async reset, active low
  input  wire logic [3:0]                reg_addr_i,       // register address
  input  wire logic [7:0]                reg_wdata_i,      // write data
  input  wire logic                      reg_wr_i,         // write strobe
  input  wire logic                      reg_rd_i,         // read strobe
  output logic [7:0]                     reg_rdata_o,      // read data, next cycle
  input  wire logic [3:0]                gp_pin_i,         // general pins, input level
  output logic [3:0]                     gp_pin_o,         // general pins, output level
  output logic [3:0]                     gp_pin_oe_o,      // general pins, output enable
  input  wire logic                      test_pos_sig_i,   // positive test signal
  input  wire logic                      test_neg_sig_i,   // negative test signal
  input  wire logic                      test_sig_en_i,    // test signals routed to pins
  input  wire logic [7:0]                stim_ch_i,        // per-channel stimulus amplifier outputs
  output logic                           test_pos_stim_out_o, // shared pin, positive
  output logic                           test_neg_stim_out_o, // shared pin, negative
  input  wire logic                      data_ready_i,     // one pulse per output data period
  input  wire logic                      input_step_i,     // pulse: input step seen
  output logic                           filter_settled_o, // filter output valid
  output bcp_pkg::bcp_analog_ctrl_type   analog_ctrl_o     // analog control bits
);
  import bcp_pkg::*;

  if (DIV_W < 8) begin : g_bad_div
    $error("bcp_top: DIV_W too small");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] breath;
    logic [7:0] stim;
    logic [7:0] electrode_off_ctrl_reg;
    logic [3:0] gpio_dir;   // 1 = input
    logic [3:0] gpio_out;
    logic [3:0] gp_s1;
    logic [3:0] gp_s2;
    logic [1:0] settle_cnt;
    logic [7:0] rdata;
    logic       pos_q;
    logic       neg_q;
  } bcp_state_type;

  bcp_state_type  st_reg;
  bcp_state_type  st_next;
  bcp_bus_req_type req;
  logic           ext_mode;
  logic           clk_in;
  logic           clk_out;
  logic [2:0]     odd_idx;
  logic [2:0]     even_idx;
  logic           stim_pos;
  logic           stim_neg;
  logic [7:0]     gpio_word;
  logic [7:0]     status_word;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ----------------------------------------------------------------
  // excitation clocks
  // ----------------------------------------------------------------
  // mode decode
  assign ext_mode = (st_reg.breath[BCP_BREATH_MODE_LSB +: 2] == BCP_MODE_EXT);

  bcp_clkgen #(
    .DIV_W (DIV_W)
  ) u_clkgen (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .run_i       (ext_mode),
    .freq_sel_i  (st_reg.cfg4[BCP_CFG4_FREQ_LSB +: 3]),
    .phase_sel_i (st_reg.breath[BCP_BREATH_PH_LSB +: 3]),
    .clk_in_o    (clk_in),
    .clk_out_o   (clk_out)
  );

  // ----------------------------------------------------------------
  // stimulus path
  // ----------------------------------------------------------------
  // odd channels 1,3,5,7 and even channels 2,4,6,8 (one-based)
  assign odd_idx  = {st_reg.stim[BCP_STIM_SEL_LSB + 2 +: 2], 1'b0};
  assign even_idx = {st_reg.stim[BCP_STIM_SEL_LSB +: 2], 1'b1};

  // amplifier off forces a quiet output
  assign stim_pos = !st_reg.stim[BCP_STIM_PD_BIT] && stim_ch_i[odd_idx];
  assign stim_neg = !st_reg.stim[BCP_STIM_PD_BIT] && stim_ch_i[even_idx];

  // detector level on gp_pin_one goes into the pin data word
  assign gpio_word   = {st_reg.gp_s2, st_reg.gpio_dir};
  assign status_word = {5'h00, ext_mode, st_reg.settle_cnt == 2'(BCP_SETTLE_PERIODS), 1'b0};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.gp_s1 = gp_pin_i;
    st_next.gp_s2 = st_reg.gp_s1;

    // shared pins: test signal when enabled, else stimulus output
    st_next.pos_q = test_sig_en_i ? test_pos_sig_i : stim_pos;
    st_next.neg_q = test_sig_en_i ? test_neg_sig_i : stim_neg;

    // settle counter over three data periods
    if (input_step_i) begin
      st_next.settle_cnt = '0;
    end else if (data_ready_i && st_reg.settle_cnt != 2'(BCP_SETTLE_PERIODS)) begin
      st_next.settle_cnt = st_reg.settle_cnt + 2'h1;
    end

    if (req.wr) begin
      unique case (req.addr)
        BCP_ADDR_CFG3:   st_next.cfg3   = req.wdata;
        BCP_ADDR_ELECTRODE_OFF_CTRL_REG:   st_next.electrode_off_ctrl_reg   = req.wdata;
        BCP_ADDR_STIM:   st_next.stim   = req.wdata;
        BCP_ADDR_BREATH: st_next.breath = req.wdata;
        BCP_ADDR_CFG4:   st_next.cfg4   = req.wdata;
        BCP_ADDR_GPIO: begin
          st_next.gpio_dir = req.wdata[3:0];
          st_next.gpio_out = req.wdata[7:4];
        end
        default: ;
      endcase
    end

    st_next.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        BCP_ADDR_CFG3:   st_next.rdata = st_reg.cfg3;
        BCP_ADDR_ELECTRODE_OFF_CTRL_REG:   st_next.rdata = st_reg.electrode_off_ctrl_reg;
        BCP_ADDR_STIM:   st_next.rdata = st_reg.stim;
        BCP_ADDR_BREATH: st_next.rdata = st_reg.breath;
        BCP_ADDR_CFG4:   st_next.rdata = st_reg.cfg4;
        BCP_ADDR_GPIO:   st_next.rdata = gpio_word;
        BCP_ADDR_STAT:   st_next.rdata = status_word;
        default:         st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg          <= '0;
      st_reg.cfg3     <= BCP_CFG3_RST;
      st_reg.cfg4     <= BCP_CFG4_RST;
      st_reg.breath   <= BCP_BREATH_RST;
      st_reg.stim     <= BCP_STIM_RST;
      st_reg.electrode_off_ctrl_reg     <= BCP_ELECTRODE_OFF_CTRL_REG_RST;
      st_reg.gpio_dir <= BCP_GPIO_RST[3:0];
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o         = st_reg.rdata;
  assign test_pos_stim_out_o = st_reg.pos_q;
  assign test_neg_stim_out_o = st_reg.neg_q;
  assign filter_settled_o    = (st_reg.settle_cnt == 2'(BCP_SETTLE_PERIODS));

  always_comb begin
    gp_pin_o    = st_reg.gpio_out;
    gp_pin_oe_o = ~st_reg.gpio_dir;
    if (ext_mode) begin
      // forced outputs regardless of direction bits
      gp_pin_oe_o[3:1] = 3'h7;
      // in-phase on three, out-of-phase on four
      gp_pin_o[2] = clk_in;
      gp_pin_o[3] = clk_out;
      gp_pin_o[1] = clk_in ^ clk_out;
    end
  end

  always_comb begin
    analog_ctrl_o.stim_amp_on  = !st_reg.stim[BCP_STIM_PD_BIT];
    analog_ctrl_o.stim_odd_ch  = odd_idx;
    analog_ctrl_o.stim_even_ch = even_idx;
    // body-drive power-down, bit active low as power-down
    analog_ctrl_o.body_drive_amp_on = st_reg.cfg3[BCP_CFG3_BD_PD_BIT];
    analog_ctrl_o.body_drive_ref_internal = st_reg.cfg3[BCP_CFG3_REF_INT_BIT];
    analog_ctrl_o.central_terminal_to_body_drive = st_reg.cfg4[BCP_CFG4_CT_BD_BIT];
    analog_ctrl_o.electrode_off_ctrl_reg_threshold = st_reg.electrode_off_ctrl_reg[BCP_ELECTRODE_OFF_CTRL_REG_TH_LSB +: 3];
    // current source only while amplifier is off
    analog_ctrl_o.bd_electrode_off_ctrl_reg_current_en = !st_reg.cfg3[BCP_CFG3_BD_PD_BIT];
  end

endmodule // bcp_top

/* dv/bcp_properties.sv */
// checker: port-level properties of the breathing clock and stimulus block
`timescale 1ns/1ns
module bcp_properties
  import bcp_pkg::*;
(
  input wire logic                clk_sys_i,           // clock
  input wire logic                rst_n_i,             // reset
  input wire logic [3:0]          reg_addr_i,          // address
  input wire logic [7:0]          reg_wdata_i,         // write data
  input wire logic                reg_wr_i,            // write strobe
  input wire logic [3:0]          gp_pin_o,            // pin level
  input wire logic [3:0]          gp_pin_oe_o,         // pin enable
  input wire logic                test_pos_sig_i,      // test pos
  input wire logic                test_neg_sig_i,      // test neg
  input wire logic                test_sig_en_i,       // test select
  input wire logic                test_pos_stim_out_o, // shared pos
  input wire logic                test_neg_stim_out_o, // shared neg
  input wire bcp_analog_ctrl_type analog_ctrl_o        // analog bits
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // shadow registers, updated on the same edge as the design
  // ----------------------------------------------------------------
  logic [7:0] cfg3_reg, electrode_off_ctrl_reg_reg, stim_reg, brth_reg, cfg4_reg;
  logic       ext_on, gpw;
  assign ext_on = (brth_reg[1:0] == BCP_MODE_EXT);
  assign gpw = reg_wr_i && (reg_addr_i == BCP_ADDR_GPIO);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg3_reg <= BCP_CFG3_RST;
      electrode_off_ctrl_reg_reg <= BCP_ELECTRODE_OFF_CTRL_REG_RST;
      stim_reg <= BCP_STIM_RST;
      brth_reg <= BCP_BREATH_RST;
      cfg4_reg <= BCP_CFG4_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        BCP_ADDR_CFG3:   cfg3_reg <= reg_wdata_i;
        BCP_ADDR_ELECTRODE_OFF_CTRL_REG:   electrode_off_ctrl_reg_reg <= reg_wdata_i;
        BCP_ADDR_STIM:   stim_reg <= reg_wdata_i;
        BCP_ADDR_BREATH: brth_reg <= reg_wdata_i;
        BCP_ADDR_CFG4:   cfg4_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_idle; !ext_on && !$past(ext_on) && !$past(gpw) |-> $stable(gp_pin_o); endproperty
  a_idle: assert property (p_idle) else $error("pins moved with no excitation");
  property p_oe; ext_on |-> gp_pin_oe_o[3:1] == 3'h7; endproperty
  a_oe: assert property (p_oe) else $error("clock pins not driven");
  property p_xor; ext_on |-> gp_pin_o[1] == (gp_pin_o[2] ^ gp_pin_o[3]); endproperty
  a_xor: assert property (p_xor) else $error("pin two not xor");
  property p_sel;
    analog_ctrl_o.stim_odd_ch == {stim_reg[4:3], 1'b0} && analog_ctrl_o.stim_even_ch == {stim_reg[2:1], 1'b1};
  endproperty
  a_sel: assert property (p_sel) else $error("stimulus channel select wrong");
  property p_spd; analog_ctrl_o.stim_amp_on == !stim_reg[0]; endproperty
  a_spd: assert property (p_spd) else $error("stimulus amp power wrong");
  property p_tst;
    test_sig_en_i |=> test_pos_stim_out_o == $past(test_pos_sig_i) && test_neg_stim_out_o == $past(test_neg_sig_i);
  endproperty
  a_tst: assert property (p_tst) else $error("test signals not on shared pins");
  property p_bpd; analog_ctrl_o.body_drive_amp_on == cfg3_reg[2]; endproperty
  a_bpd: assert property (p_bpd) else $error("body drive power wrong");
  property p_ref; analog_ctrl_o.body_drive_ref_internal == cfg3_reg[3]; endproperty
  a_ref: assert property (p_ref) else $error("body drive reference wrong");
  property p_ct; analog_ctrl_o.central_terminal_to_body_drive == cfg4_reg[2]; endproperty
  a_ct: assert property (p_ct) else $error("central terminal route wrong");
  property p_th; analog_ctrl_o.electrode_off_ctrl_reg_threshold == electrode_off_ctrl_reg_reg[7:5]; endproperty
  a_th: assert property (p_th) else $error("threshold field wrong");
  property p_cur; analog_ctrl_o.body_drive_amp_on |-> !analog_ctrl_o.bd_electrode_off_ctrl_reg_current_en; endproperty
  a_cur: assert property (p_cur) else $error("current source on with amp on");
endmodule // bcp_properties

bind bcp_top bcp_properties u_prop (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .gp_pin_o,
  .gp_pin_oe_o, .test_pos_sig_i, .test_neg_sig_i, .test_sig_en_i, .test_pos_stim_out_o, .test_neg_stim_out_o,
  .analog_ctrl_o);

/* dv/bcp_far_side.sv */
// far-side model: pin wires, breathing circuit load and pulse detector
`timescale 1ns/1ns
module bcp_far_side (
  input  wire logic       clk_sys_i, // clock
  input  wire logic [3:0] pin_o_i,   // device drive level
  input  wire logic [3:0] pin_oe_i,  // device drive enable
  input  wire logic       det_i,     // detector result
  output logic      [3:0] pin_lvl_o  // resolved wire level
);
  // undriven lines two to four wander so a stale value never reads as valid; line one carries the detector
  logic [3:0] alt_reg = 4'h5;
  always_ff @(posedge clk_sys_i) begin
    alt_reg <= ~alt_reg;
  end
  always_comb begin
    pin_lvl_o = pin_oe_i & pin_o_i | ~pin_oe_i & {alt_reg[3:1], det_i};
  end
endmodule // bcp_far_side

/* dv/tb.sv */
// testbench: registers, excitation clocks, stimulus path, body drive, settling
`timescale 1ns/1ns
module tb;
  import bcp_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, det = 1'b0;
  logic [3:0] reg_addr_i = 4'h0, gp_pin_i, gp_pin_o, gp_pin_oe_o;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, stim_ch_i = 8'h00;
  logic test_pos_sig_i = 1'b0, test_neg_sig_i = 1'b0, test_sig_en_i = 1'b0;
  logic data_ready_i = 1'b0, input_step_i = 1'b0, filter_settled_o, test_pos_stim_out_o, test_neg_stim_out_o;
  bcp_analog_ctrl_type analog_ctrl_o;
  int n_tests = 0, n_mismatch = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  bcp_top #(.DIV_W(8)) dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .gp_pin_i, .gp_pin_o, .gp_pin_oe_o, .test_pos_sig_i, .test_neg_sig_i, .test_sig_en_i, .stim_ch_i,
    .test_pos_stim_out_o, .test_neg_stim_out_o, .data_ready_i, .input_step_i, .filter_settled_o, .analog_ctrl_o);
  bcp_far_side far (.clk_sys_i, .pin_o_i(gp_pin_o), .pin_oe_i(gp_pin_oe_o), .det_i(det), .pin_lvl_o(gp_pin_i));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    d = reg_rdata_o;
  endtask
  // cycles until pin three next changes
  task automatic tog(output int n);
    logic v;
    v = gp_pin_o[2];
    n = 0;
    while (gp_pin_o[2] === v) begin
      cyc(1);
      n++;
      if (n > 600) begin
        n_mismatch++;
        final_report();
      end
    end
  endtask
  task automatic pulse_dr(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      data_ready_i <= 1'b1;
      cyc(1);
      data_ready_i <= 1'b0;
      cyc(2);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [3:0] ad [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hF};
    logic [7:0] ex [7] = '{8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], d);
      chk("reset read", ex[i], d);
    end
    rd(BCP_ADDR_GPIO, d);
    chk("gpio dir", 8'h0F, d & 8'h0F);
    chk("oe", 8'h00, gp_pin_oe_o);
    chk("body on", 8'h01, analog_ctrl_o.body_drive_amp_on);
    $display("done reset");
  endtask
  task automatic t_breath;
    logic [7:0] d;
    int n;
    wr(BCP_ADDR_BREATH, 8'h01);
    chk("forced oe", 8'h0E, gp_pin_oe_o);
    rd(BCP_ADDR_STAT, d);
    chk("ext flag", 8'h04, d & 8'h04);
    chk("xor", gp_pin_o[2] ^ gp_pin_o[3], gp_pin_o[1]);
    for (int f = 0; f < 8; f++) begin
      wr(BCP_ADDR_CFG4, 8'(f << 5));
      repeat (3) tog(n);
      chk("half period", 16'(2 << f), 16'(n));
    end
    wr(BCP_ADDR_CFG4, 8'h60);
    for (int p = 0; p < 4; p++) begin
      wr(BCP_ADDR_BREATH, 8'((p << 2) | 1));
      repeat (2) tog(n);
      n = 0;
      while (gp_pin_o[3] === gp_pin_o[2]) begin
        cyc(1);
        n++;
        if (n > 600) begin
          n_mismatch++;
          final_report();
        end
      end
      chk("phase lag", 8'(p * 4), 8'(n));
    end
    wr(BCP_ADDR_BREATH, 8'h00);
    chk("idle oe", 8'h00, gp_pin_oe_o);
    $display("done breath");
  endtask
  task automatic t_stim;
    logic [2:0] o, e;
    for (int s = 0; s < 16; s++) begin
      wr(BCP_ADDR_STIM, 8'(s << 1));
      o = {s[3:2], 1'b0};
      e = {s[1:0], 1'b1};
      chk("odd", 8'(o), 8'(analog_ctrl_o.stim_odd_ch));
      chk("even", 8'(e), 8'(analog_ctrl_o.stim_even_ch));
      chk("amp on", 8'h01, analog_ctrl_o.stim_amp_on);
      @(posedge clk_sys_i);
      stim_ch_i <= 8'(1 << (s[0] ? e : o));
      cyc(2);
      chk("pos pin", 16'(!s[0]), test_pos_stim_out_o);
      chk("neg pin", 16'(s[0]), test_neg_stim_out_o);
    end
    wr(BCP_ADDR_STIM, 8'h01);
    chk("amp off", 8'h00, analog_ctrl_o.stim_amp_on);
    cyc(1);
    chk("off pos", 8'h00, test_pos_stim_out_o);
    chk("off neg", 8'h00, test_neg_stim_out_o);
    @(posedge clk_sys_i);
    test_sig_en_i <= 1'b1;
    test_neg_sig_i <= 1'b1;
    cyc(2);
    chk("test mux", 8'h02, {test_neg_stim_out_o, test_pos_stim_out_o});
    $display("done stim");
  endtask
  task automatic t_body;
    // steps body-drive power and reference through all four settings and checks the current source for each
    for (int c = 0; c < 4; c++) begin
      wr(BCP_ADDR_CFG3, 8'(c << 2));
      chk("bd on", 8'(c & 1), analog_ctrl_o.body_drive_amp_on);
      chk("bd ref", 8'(c >> 1), analog_ctrl_o.body_drive_ref_internal);
      chk("bd cur", 8'(~c & 1), analog_ctrl_o.bd_electrode_off_ctrl_reg_current_en);
    end
    wr(BCP_ADDR_CFG4, 8'h04);
    chk("ct route", 8'h01, analog_ctrl_o.central_terminal_to_body_drive);
    for (int t = 0; t < 8; t++) begin
      wr(BCP_ADDR_ELECTRODE_OFF_CTRL_REG, 8'(t << 5));
      chk("thresh", 8'(t), 8'(analog_ctrl_o.electrode_off_ctrl_reg_threshold));
    end
    $display("done body");
  endtask
  task automatic t_detect;
    logic [7:0] d;
    @(posedge clk_sys_i);
    det <= 1'b1;
    cyc(4);
    rd(BCP_ADDR_GPIO, d);
    chk("detect hi", 8'h10, d & 8'h10);
    det <= 1'b0;
    cyc(4);
    rd(BCP_ADDR_GPIO, d);
    chk("detect lo", 8'h00, d & 8'h10);
    $display("done detect");
  endtask
  task automatic t_settle;
    logic [7:0] d;
    @(posedge clk_sys_i);
    input_step_i <= 1'b1;
    cyc(1);
    input_step_i <= 1'b0;
    pulse_dr(2);
    chk("unsettled", 8'h00, filter_settled_o);
    pulse_dr(1);
    chk("settled", 8'h01, filter_settled_o);
    rd(BCP_ADDR_STAT, d);
    chk("stat settled", 8'h02, d & 8'h02);
    $display("done settle");
  endtask
  initial begin
    cyc(10);
    rst_n_i <= 1'b1;
    t_reset();
    t_breath();
    t_stim();
    t_body();
    t_detect();
    t_settle();
    final_report();
  end
endmodule // tb
